// ---- status_srq.sv ----
// status reporting and service-request logic of the optical switch
// assumes a parser that hands over decoded commands and error pulses, and a bus engine for polls
//
// How it works
// RL1: completion query answers 1 when all commands ran, else 0.
// RL2: identification query streams maker, series and firmware text.
// RL3: three eight-bit registers: condition, event status, request mask.
// RL4: condition bit 2 shows settled mechanism; all other bits read 0.
// RL5: condition query returns the condition value, 4 when settled.
// RL6: events set sticky status bits that stay until cleared.
// RL7: status layout 7,6,5,4,2,0 as events; bits 3 and 1 read 0.
// RL8: calibration error after power-up or self-check sets bit 7.
// RL9: parser syntax error in a mnemonic sets bit 5.
// RL10: a waiting response message sets bit 4.
// RL11: each rise of condition bit 2 sets status bit 2.
// RL12: out-of-range parameter sets bit 0.
// RL13: during power-up status is 0, poll only; afterwards only settled set.
// RL14: status clear and full clear zero the whole status register.
// RL15: status query clears register after answering only if bit 6 was set.
// RL16: unmasked status rise raises request and bit 6; mask 6,3,1 unused.
// RL17: first unmasked rise among several triggers the request.
// RL18: first poll after a request shows bit 6; later polls do not.
// RL19: after a status answer with bit 6 set, later queries return 0.
// RL20: mask clears at power-up, full clear and universal device clear.
// RL21: host acknowledges a request by serial poll or status query.
// RL22: host should clear status before a move to see only it.
// RL23: status query answers as a three-digit decimal number.
// RL24: mask write loads its parameter into the request mask.
// RL25: an event in the same cycle as a clear survives the clear.
`timescale 1ns/1ns
module status_srq (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // decoded commands from the parser
  input  wire logic              cmd_valid,
  input  wire status_pkg::cmd_t  cmd_code,
  input  wire logic [7:0]        cmd_param,
  output logic                   cmd_ready,
  input  wire logic              cmds_idle,
  // event sources
  input  wire logic              powerup_done,
  input  wire logic              mech_settled,
  input  wire logic              cal_error,
  input  wire logic              syntax_error,
  input  wire logic              param_error,
  input  wire logic              msg_waiting,
  // bus side
  input  wire logic              poll_req,
  input  wire logic              device_clear,
  output logic                   poll_valid,
  output logic [7:0]             poll_data,
  output logic                   srq,
  // answer characters toward the output buffer
  output logic                   resp_valid,
  output logic [7:0]             resp_data,
  output logic                   resp_last,
  input  wire logic              resp_ready
);

  typedef struct packed {
    status_pkg::fsm_t fsm;
    status_pkg::src_t src;
    logic [7:0]       cond;
    logic [7:0]       status;
    logic [7:0]       mask;
    logic             settled_q;
    logic             pu_done_q;
    logic [7:0]       num_value;
    logic [7:0]       one_char;
    logic [4:0]       idx;
    logic             cmd_ready;
    logic             resp_valid;
    logic [7:0]       resp_data;
    logic             resp_last;
    logic             poll_valid;
    logic [7:0]       poll_data;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  text_if tx ();

  id_rom u_id_rom (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tx    (tx.rom)
  );

  dec3_format u_dec3_format (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tx    (tx.fmt)
  );

  // helpers see the index and the captured value straight from state
  assign tx.rom_addr  = st.idx;
  assign tx.fmt_value = st.num_value;

  always_comb
  begin
    logic       take;
    logic       clear_all;
    logic       clear_req;
    logic [7:0] events;
    logic [7:0] base;
    logic [7:0] rises;
    logic [7:0] pick;
    logic       last;
    take      = cmd_valid && st.cmd_ready;
    clear_all = 1'b0;
    clear_req = 1'b0;
    events    = 8'h00;
    pick      = 8'h00;
    last      = 1'b0;
    base      = 8'h00;
    rises     = 8'h00;
    next_st   = st;
    next_st.poll_valid = 1'b0;

    // condition register follows the mechanism; unused bits stay 0
    next_st.cond = status_pkg::COND_RST;
    next_st.cond[status_pkg::COND_SETTLED] = mech_settled; // RL4
    next_st.settled_q = st.cond[status_pkg::COND_SETTLED];
    next_st.pu_done_q = powerup_done;

    // event sources; bits 3 and 1 have no source and stay 0
    events[status_pkg::ST_SELFTEST] = cal_error; // RL8
    events[status_pkg::ST_SYNTAX]   = syntax_error; // RL9
    events[status_pkg::ST_MESSAGE]  = msg_waiting; // RL10
    events[status_pkg::ST_SETTLED]  = st.cond[status_pkg::COND_SETTLED] && !st.settled_q; // RL11
    events[status_pkg::ST_PARAM]    = param_error; // RL12

    // bus poll: report bit 6 once, then drop it as the acknowledge
    if (poll_req)
    begin
      next_st.poll_valid = 1'b1;
      next_st.poll_data  = st.status; // RL18
      clear_req          = 1'b1; // RL21
    end

    if (take)
    begin
      unique case (cmd_code)
        status_pkg::CMD_OPC_QUERY:
        begin
          next_st.src      = status_pkg::SRC_CHAR;
          next_st.one_char = cmds_idle ? status_pkg::ASCII_ONE : status_pkg::ASCII_ZERO; // RL1
          next_st.idx      = 5'h00;
          next_st.fsm      = status_pkg::FS_FETCH;
        end
        status_pkg::CMD_IDENT_QUERY:
        begin
          next_st.src = status_pkg::SRC_ID; // RL2
          next_st.idx = 5'h00;
          next_st.fsm = status_pkg::FS_FETCH;
        end
        status_pkg::CMD_COND_QUERY:
        begin
          next_st.src       = status_pkg::SRC_NUM;
          next_st.num_value = st.cond; // RL5
          next_st.idx       = 5'h00;
          next_st.fsm       = status_pkg::FS_FETCH;
        end
        status_pkg::CMD_STAT_QUERY:
        begin
          next_st.src       = status_pkg::SRC_NUM;
          next_st.num_value = st.status; // RL23
          next_st.idx       = 5'h00;
          next_st.fsm       = status_pkg::FS_FETCH;
          clear_all         = st.status[status_pkg::ST_REQUEST]; // RL15 RL19 RL21
        end
        status_pkg::CMD_STAT_CLEAR:
        begin
          clear_all = 1'b1; // RL14
        end
        status_pkg::CMD_FULL_CLEAR:
        begin
          clear_all    = 1'b1; // RL14
          next_st.mask = status_pkg::MASK_RST; // RL20
        end
        status_pkg::CMD_MASK_WRITE:
        begin
          next_st.mask = cmd_param; // RL24
        end
        status_pkg::CMD_NOP:
        begin
          next_st.mask = st.mask;
        end
      endcase
    end

    if (device_clear)
      next_st.mask = status_pkg::MASK_RST; // RL20

    // clears act on the old contents; new events are merged afterwards so they survive
    base = clear_all ? status_pkg::STATUS_RST : st.status; // RL14
    if (clear_req)
      base[status_pkg::ST_REQUEST] = 1'b0; // RL18
    rises = events & ~base & st.mask & status_pkg::MASK_LIVE; // RL16
    next_st.status = base | events; // RL6 RL25
    // a pending request is not re-raised, so only the first rise counts
    if (|rises && !base[status_pkg::ST_REQUEST])
      next_st.status[status_pkg::ST_REQUEST] = 1'b1; // RL16 RL17
    next_st.status[3] = 1'b0; // RL7
    next_st.status[1] = 1'b0; // RL7

    // power-up: hold zero, then leave only the settled bit
    if (!powerup_done)
      next_st.status = status_pkg::STATUS_RST; // RL13
    else if (!st.pu_done_q)
    begin
      next_st.status = status_pkg::STATUS_RST;
      next_st.status[status_pkg::ST_SETTLED] = 1'b1; // RL13
    end

    // answer streamer: one character per fetch, load and hold round
    unique case (st.fsm)
      status_pkg::FS_IDLE:
      begin
        next_st.resp_valid = 1'b0;
      end
      status_pkg::FS_FETCH:
      begin
        next_st.fsm = status_pkg::FS_LOAD;
      end
      status_pkg::FS_LOAD:
      begin
        unique case (st.src)
          status_pkg::SRC_CHAR:
          begin
            pick = st.one_char;
            last = 1'b1;
          end
          status_pkg::SRC_NUM:
          begin
            pick = tx.fmt_digits[8*(status_pkg::NUM_DIGITS-1-int'(st.idx)) +: 8]; // RL23
            last = (st.idx == status_pkg::NUM_LAST_IDX);
          end
          status_pkg::SRC_ID:
          begin
            pick = tx.rom_data; // RL2
            last = (st.idx == status_pkg::ID_LAST_IDX);
          end
          default:
          begin
            pick = 8'h00;
            last = 1'b1;
          end
        endcase
        next_st.resp_valid = 1'b1;
        next_st.resp_data  = pick;
        next_st.resp_last  = last;
        next_st.fsm        = status_pkg::FS_HOLD;
      end
      status_pkg::FS_HOLD:
      begin
        // the output buffer may stall us; the character stands until taken
        if (resp_ready)
        begin
          next_st.resp_valid = 1'b0;
          if (st.resp_last)
            next_st.fsm = status_pkg::FS_IDLE;
          else
          begin
            next_st.idx = st.idx + 5'h01;
            next_st.fsm = status_pkg::FS_FETCH;
          end
        end
      end
      default:
      begin
        next_st.fsm        = status_pkg::FS_IDLE;
        next_st.resp_valid = 1'b0;
      end
    endcase

    // commands are refused while powering up and while an answer streams out
    next_st.cmd_ready = (next_st.fsm == status_pkg::FS_IDLE) && powerup_done; // RL13
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st        <= '0;
      st.fsm    <= status_pkg::FS_IDLE;
      st.src    <= status_pkg::SRC_CHAR;
      st.status <= status_pkg::STATUS_RST;
      st.mask   <= status_pkg::MASK_RST; // RL20
      st.cond   <= status_pkg::COND_RST;
    end
    else
      st <= next_st; // RL3
  end

  assign cmd_ready  = st.cmd_ready;
  assign poll_valid = st.poll_valid;
  assign poll_data  = st.poll_data;
  assign srq        = st.status[status_pkg::ST_REQUEST]; // RL16
  assign resp_valid = st.resp_valid;
  assign resp_data  = st.resp_data;
  assign resp_last  = st.resp_last;

endmodule : status_srq

// ---- status_pkg.sv ----
// constants, encodings and state types shared by the status and service-request logic
// assumes a single clock domain; nothing here holds state
package status_pkg;

  // register geometry
  localparam int          REG_W          = 8;
  localparam logic [7:0]  STATUS_RST     = 8'h00;
  localparam logic [7:0]  MASK_RST       = 8'h00;
  localparam logic [7:0]  COND_RST       = 8'h00;

  // condition register field
  localparam int          COND_SETTLED   = 2;

  // event status field positions
  localparam int          ST_SELFTEST    = 7;
  localparam int          ST_REQUEST     = 6;
  localparam int          ST_SYNTAX      = 5;
  localparam int          ST_MESSAGE     = 4;
  localparam int          ST_SETTLED     = 2;
  localparam int          ST_PARAM       = 0;

  // mask bits that take part in request generation (6, 3 and 1 have no function)
  localparam logic [7:0]  MASK_LIVE      = 8'hb5;

  // text answers
  localparam logic [7:0]  ASCII_ZERO     = 8'h30;
  localparam logic [7:0]  ASCII_ONE      = 8'h31;
  localparam int          NUM_DIGITS     = 3;
  localparam logic [4:0]  NUM_LAST_IDX   = 5'h02;

  // identification text; the value is arbitrary and names no real maker
  localparam int          ID_LEN         = 24;
  localparam int          ID_AW          = 5;
  localparam logic [4:0]  ID_LAST_IDX    = 5'h17;
  localparam logic [8*ID_LEN-1:0] ID_TEXT = "NEUTRAL,OPTSWITCH,0,0.01";

  // commands handed over by the parser
  typedef enum logic [2:0] {
    CMD_OPC_QUERY   = 3'h0,
    CMD_IDENT_QUERY = 3'h1,
    CMD_COND_QUERY  = 3'h2,
    CMD_STAT_QUERY  = 3'h3,
    CMD_STAT_CLEAR  = 3'h4,
    CMD_FULL_CLEAR  = 3'h5,
    CMD_MASK_WRITE  = 3'h6,
    CMD_NOP         = 3'h7
  } cmd_t;

  // answer streamer states
  typedef enum logic [3:0] {
    FS_IDLE  = 4'b0001,
    FS_FETCH = 4'b0010,
    FS_LOAD  = 4'b0100,
    FS_HOLD  = 4'b1000
  } fsm_t;

  // where the characters of an answer come from
  typedef enum logic [1:0] {
    SRC_CHAR = 2'h0,
    SRC_NUM  = 2'h1,
    SRC_ID   = 2'h2
  } src_t;

endpackage : status_pkg

// ---- text_if.sv ----
// carrier between the status top and its text helpers (identity store, decimal formatter)
// assumes all three sit on the same clock
`timescale 1ns/1ns
interface text_if;
  logic [status_pkg::ID_AW-1:0]             rom_addr;
  logic [7:0]                               rom_data;
  logic [status_pkg::REG_W-1:0]             fmt_value;
  logic [8*status_pkg::NUM_DIGITS-1:0]      fmt_digits;

  modport ctrl (output rom_addr, output fmt_value, input rom_data, input fmt_digits);
  modport rom  (input rom_addr, output rom_data);
  modport fmt  (input fmt_value, output fmt_digits);
endinterface : text_if

// ---- id_rom.sv ----
// identification text store, one character per address, read data registered
// assumes the address is held stable for the cycle before the data is used
`timescale 1ns/1ns
module id_rom (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // lookup
  text_if.rom       tx
);

  typedef struct packed {
    logic [7:0] data;
  } rom_state_t;

  rom_state_t st;
  rom_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (int'(tx.rom_addr) < status_pkg::ID_LEN)
      next_st.data = status_pkg::ID_TEXT[8*(status_pkg::ID_LEN-1-int'(tx.rom_addr)) +: 8]; // RL2
    else
      next_st.data = 8'h00;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign tx.rom_data = st.data;

endmodule : id_rom

// ---- dec3_format.sv ----
// eight-bit value to three ascii decimal digits, hundreds first, registered
// assumes the value is held for one cycle before the digits are used
`timescale 1ns/1ns
module dec3_format (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // conversion
  text_if.fmt       tx
);

  typedef struct packed {
    logic [8*status_pkg::NUM_DIGITS-1:0] digits;
  } fmt_state_t;

  fmt_state_t st;
  fmt_state_t next_st;

  always_comb
  begin
    logic [7:0] hund;
    logic [7:0] tens;
    logic [7:0] ones;
    hund = tx.fmt_value / 8'h64;
    tens = (tx.fmt_value / 8'h0a) % 8'h0a;
    ones = tx.fmt_value % 8'h0a;
    next_st = st;
    next_st.digits = {status_pkg::ASCII_ZERO + hund,
                      status_pkg::ASCII_ZERO + tens,
                      status_pkg::ASCII_ZERO + ones}; // RL23
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign tx.fmt_digits = st.digits;

endmodule : dec3_format

// ---- status_srq_sva.sv ----
// timing checks on the status and service-request ports
// bound to every status_srq instance; watches its ports only
`timescale 1ns/1ns
module status_srq_sva (
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst_n,
  // command side
  input wire logic             cmd_valid,
  input wire status_pkg::cmd_t cmd_code,
  input wire logic             cmd_ready,
  input wire logic             cmds_idle,
  // events
  input wire logic             powerup_done,
  input wire logic             cal_error,
  input wire logic             syntax_error,
  input wire logic             param_error,
  input wire logic             msg_waiting,
  // bus side
  input wire logic             poll_req,
  input wire logic             poll_valid,
  input wire logic [7:0]       poll_data,
  input wire logic             srq,
  // answers
  input wire logic             resp_valid,
  input wire logic [7:0]       resp_data,
  input wire logic             resp_last,
  input wire logic             resp_ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  poll_request_a: assert property (poll_req && srq |=> poll_valid && poll_data[6])
    else $error("poll lost the request bit");
  bits_zero_a: assert property (poll_valid |-> !poll_data[3] && !poll_data[1])
    else $error("unused status bit set");
  powerup_zero_a: assert property (poll_req && !powerup_done |=> poll_data == 8'h00)
    else $error("status not zero during power-up");
  selftest_bit_a: assert property (cal_error && $past(powerup_done) ##1 poll_req |=> poll_data[7])
    else $error("self-test bit not set");
  syntax_bit_a: assert property (syntax_error && $past(powerup_done) ##1 poll_req |=> poll_data[5])
    else $error("syntax bit not set");
  param_bit_a: assert property (param_error && $past(powerup_done) ##1 poll_req |=> poll_data[0])
    else $error("parameter bit not set");
  message_bit_a: assert property (msg_waiting && $past(powerup_done) ##1 poll_req |=> poll_data[4])
    else $error("message bit not set");
  ready_wait_a: assert property (!powerup_done |=> !cmd_ready)
    else $error("command taken during power-up");
  // first character is registered out of the load state: take, fetch, load, then visible
  answer_time_a: assert property (cmd_valid && cmd_ready && cmd_code <= status_pkg::CMD_STAT_QUERY
    |-> ##3 resp_valid)
    else $error("answer late");
  opc_answer_a: assert property (cmd_valid && cmd_ready && cmd_code == status_pkg::CMD_OPC_QUERY
    |-> ##3 resp_valid && resp_last && resp_data == {7'h18, $past(cmds_idle, 3)})
    else $error("completion answer wrong");
  resp_hold_a: assert property (resp_valid && !resp_ready
    |=> resp_valid && $stable(resp_data) && $stable(resp_last))
    else $error("answer character not held");
endmodule : status_srq_sva
bind status_srq status_srq_sva sva (
  .mclk         (mclk),
  .rst_n        (rst_n),
  .cmd_valid    (cmd_valid),
  .cmd_code     (cmd_code),
  .cmd_ready    (cmd_ready),
  .cmds_idle    (cmds_idle),
  .powerup_done (powerup_done),
  .cal_error    (cal_error),
  .syntax_error (syntax_error),
  .param_error  (param_error),
  .msg_waiting  (msg_waiting),
  .poll_req     (poll_req),
  .poll_valid   (poll_valid),
  .poll_data    (poll_data),
  .srq          (srq),
  .resp_valid   (resp_valid),
  .resp_data    (resp_data),
  .resp_last    (resp_last),
  .resp_ready   (resp_ready)
);

// ---- host_model.sv ----
// remote host: takes answer characters, slowly when asked to stall
// assumes the answer stream of status_srq on the same clock
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic       mclk,
  // pacing
  input wire logic       stall,
  // answer stream
  input wire logic       resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic       resp_last,
  output logic           resp_ready
);
  logic [7:0] rx[$];
  int         ends = 0;
  initial resp_ready = 1'b0;
  // stalling raises ready on every second cycle only, to exercise the hold path
  always @(posedge mclk)
  begin
    if (resp_valid === 1'b1 && resp_ready)
    begin
      rx.push_back(resp_data);
      ends += int'(resp_last);
    end
    #1 resp_ready = stall ? ~resp_ready : 1'b1;
  end
endmodule : host_model

// ---- status_srq_tb.sv ----
// self-checking bench for status_srq with a host model on the answer stream
// assumes the checker is bound from its own file
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module status_srq_tb;
  logic             mclk, rst_n, cmd_valid, cmd_ready, cmds_idle, powerup_done, mech_settled;
  logic             cal_error, syntax_error, param_error, msg_waiting, poll_req, device_clear;
  logic             poll_valid, srq, resp_valid, resp_last, resp_ready, stall;
  status_pkg::cmd_t cmd_code;
  logic [7:0]       cmd_param, poll_data, resp_data;
  int               err_count = 0;
  int               checks = 0;

  status_srq dut (.mclk, .rst_n, .cmd_valid, .cmd_code, .cmd_param, .cmd_ready, .cmds_idle,
    .powerup_done, .mech_settled, .cal_error, .syntax_error, .param_error, .msg_waiting,
    .poll_req, .device_clear, .poll_valid, .poll_data, .srq, .resp_valid, .resp_data,
    .resp_last, .resp_ready);
  host_model host (.mclk, .stall, .resp_valid, .resp_data, .resp_last, .resp_ready);

  always #2 mclk = ~mclk;

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic issue(input status_pkg::cmd_t c, input logic [7:0] p, input logic ev);
    int n = 0;
    {cmd_valid, cmd_code, cmd_param, syntax_error} = {1'b1, c, p, ev};
    @(posedge mclk);
    while (cmd_ready !== 1'b1 && n < 200)
    begin
      @(posedge mclk);
      n++;
    end
    #1 {cmd_valid, syntax_error} = 2'b00;
    // one idle edge, so a following call never re-raises a strobe in the same step
    tick;
    if (n >= 200) err_count++;
  endtask : issue

  task automatic ask(input status_pkg::cmd_t c, input int len, input logic [191:0] exp);
    int n = 0;
    int e = host.ends;
    host.rx.delete();
    issue(c, 8'h00, 1'b0);
    while (host.ends == e && n < 400)
    begin
      tick;
      n++;
    end
    `CHK(host.rx.size(), len)
    for (int i = 0; i < len && i < host.rx.size(); i++)
      `CHK(host.rx[i], exp[8*(len-1-i) +: 8])
  endtask : ask

  task automatic poll(input logic [7:0] exp);
    poll_req = 1'b1;
    tick;
    poll_req = 1'b0;
    `CHK(poll_valid, 1'b1)
    `CHK(poll_data, exp)
    tick;
  endtask : poll

  task automatic pulse(input logic [3:0] m);
    {cal_error, syntax_error, param_error, msg_waiting} = m;
    tick;
    {cal_error, syntax_error, param_error, msg_waiting} = 4'h0;
  endtask : pulse

  function automatic logic [191:0] dec3(input logic [7:0] v);
    return {168'h0, 8'(8'h30 + v / 100), 8'(8'h30 + v / 10 % 10), 8'(8'h30 + v % 10)};
  endfunction : dec3

  task automatic t_powerup;
    poll(8'h00);
    powerup_done = 1'b1;
    tick;
    tick;
    poll(8'h04);
    ask(status_pkg::CMD_COND_QUERY, 3, dec3(8'h04));
    cmds_idle = 1'b0;
    ask(status_pkg::CMD_OPC_QUERY, 1, 192'h30);
    cmds_idle = 1'b1;
    ask(status_pkg::CMD_OPC_QUERY, 1, 192'h31);
    stall = 1'b1;
    ask(status_pkg::CMD_IDENT_QUERY, 24, status_pkg::ID_TEXT);
    stall = 1'b0;
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_events;
    issue(status_pkg::CMD_STAT_CLEAR, 8'h00, 1'b0);
    poll(8'h00);
    pulse(4'hf);
    poll(8'hb1);
    poll(8'hb1);
    ask(status_pkg::CMD_STAT_QUERY, 3, dec3(8'hb1));
    poll(8'hb1);
    issue(status_pkg::CMD_FULL_CLEAR, 8'h00, 1'b0);
    poll(8'h00);
    $display("test events done");
  endtask : t_events

  task automatic t_request;
    issue(status_pkg::CMD_MASK_WRITE, 8'h6a, 1'b0);
    pulse(4'h2);
    `CHK(srq, 1'b0)
    tick;
    pulse(4'h4);
    `CHK(srq, 1'b1)
    poll(8'h61);
    poll(8'h21);
    issue(status_pkg::CMD_STAT_CLEAR, 8'h00, 1'b0);
    pulse(4'h4);
    ask(status_pkg::CMD_STAT_QUERY, 3, dec3(8'h60));
    `CHK(srq, 1'b0)
    ask(status_pkg::CMD_STAT_QUERY, 3, dec3(8'h00));
    $display("test request done");
  endtask : t_request

  task automatic t_settle;
    issue(status_pkg::CMD_MASK_WRITE, 8'h24, 1'b0);
    issue(status_pkg::CMD_NOP, 8'h00, 1'b0);
    issue(status_pkg::CMD_STAT_CLEAR, 8'h00, 1'b0);
    mech_settled = 1'b0;
    repeat (3) tick;
    mech_settled = 1'b1;
    repeat (3) tick;
    `CHK(srq, 1'b1)
    pulse(4'h4);
    poll(8'h64);
    device_clear = 1'b1;
    tick;
    device_clear = 1'b0;
    issue(status_pkg::CMD_STAT_CLEAR, 8'h00, 1'b1);
    `CHK(srq, 1'b0)
    poll(8'h20);
    $display("test settle done");
  endtask : t_settle

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial
  begin
    {mclk, rst_n, cmd_valid, cmd_param, powerup_done, poll_req, device_clear, stall} = '0;
    {cal_error, syntax_error, param_error, msg_waiting} = 4'h0;
    {cmds_idle, mech_settled} = 2'b11;
    cmd_code = status_pkg::CMD_NOP;
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    tick;
    t_powerup;
    t_events;
    t_request;
    t_settle;
    final_report;
  end

  // whole run needs a few hundred cycles; this is ample margin
  initial
  begin
    #200000;
    err_count++;
    final_report;
  end
endmodule : status_srq_tb
